// ==== src/eipl_irq_latch.sv ====
// external interrupt pin latch with register port
`timescale 1ns/1ps
`include "eipl_defines.svh"
// Behaviour
// RULE1: a falling edge on the pin sets the request latch.
// RULE2: the latch clears on vector fetch, software acknowledge or reset.
// RULE3: with mode 1 the pin requests on a falling edge and while low.
// RULE4: in mode 1 the request ends only after both an acknowledge and a high pin, in any order.
// RULE5: in mode 1 the request stays up while the pin is low, even after an acknowledge.
// RULE6: a vector fetch makes an acknowledge pulse that clears the latch.
// RULE7: writing 1 to the acknowledge bit makes the same pulse.
// RULE8: an edge after an acknowledge sets the latch again.
// RULE9: an unmasked latched request vectors through the handler word at fffa.
// RULE10: reset clears the latch and the mode bit even with the pin low.
// RULE11: with mode 0 only falling edges request and an acknowledge clears at once.
// RULE12: the pending flag shows the latch regardless of the mask.
// RULE13: the pin level is given to the processor for branch-on-pin tests.
// RULE14: with break-clear enabled, software acknowledges in break clear the latch for good.
// RULE15: with break-clear disabled, acknowledge writes in break change no flags.
// RULE16: software using level mode should mask requests inside its handler.
// RULE17: the pin passes two flip-flops before edge or level logic.
module eipl_irq_latch (
  // clock and reset
  input  wire logic                     sys_clk,
  input  wire logic                     rst_b,
  // interrupt pin, active low
  input  wire logic                     irqPinB,
  // processor side
  input  wire logic                     vecFetch,
  input  wire logic                     breakState,
  output logic                          irqReq,
  output logic [15:0]                   vectorAddr,
  output logic                          pinHigh,
  // register port
  input  wire logic [`EIPL_ADDR_W-1:0]  regAddr,
  input  wire logic [7:0]               regWrData,
  input  wire logic                     regWr,
  input  wire logic                     regRd,
  output logic [7:0]                    regRdData
);
  eipl_pkg::eipl_regs_t cur_r, cur_nxt;
  logic pinLevel, fallPulse, ackPulse, swAck, latched;

  eipl_pin_sync #(.STAGES(`EIPL_SYNC_STAGES)) uSync (
    .sysClk    (sys_clk),
    .rstB      (rst_b),
    .pinInB    (irqPinB),
    .pinLevel  (pinLevel),
    .fallPulse (fallPulse)
  );

  assign swAck = regWr && regAddr == `EIPL_STATUS_CTRL && regWrData[`EIPL_BIT_ACK]; // see RULE7

  eipl_ack_gate uAck (
    .vecFetch   (vecFetch),
    .swAck      (swAck),
    .breakState (breakState),
    .breakClrEn (cur_r.breakClrEn),
    .ackPulse   (ackPulse)
  );

  // held state: acknowledged but pin still low in mode 1
  assign latched = cur_r.state != eipl_pkg::EIPL_IDLE; // see RULE12
  assign irqReq     = latched & ~cur_r.mask; // see RULE9
  assign vectorAddr = `EIPL_VEC_ADDR_HI; // see RULE9
  assign pinHigh    = pinLevel; // see RULE13
  assign regRdData  = cur_r.rdData;

  always_comb
  begin
    cur_nxt = cur_r;
    cur_nxt.rdData = 8'h00;
    unique case (cur_r.state)
      eipl_pkg::EIPL_IDLE:
      begin
        if (fallPulse)
          cur_nxt.state = eipl_pkg::EIPL_LATCHED; // see RULE1 see RULE8
      end
      eipl_pkg::EIPL_LATCHED:
      begin
        // edge arriving with the acknowledge wins and re-latches
        if (ackPulse && !fallPulse)
        begin
          if (cur_r.mode && !pinLevel)
            cur_nxt.state = eipl_pkg::EIPL_HELD; // see RULE4 see RULE5
          else
            cur_nxt.state = eipl_pkg::EIPL_IDLE; // see RULE2 see RULE11
        end
      end
      eipl_pkg::EIPL_HELD:
      begin
        if (fallPulse)
          cur_nxt.state = eipl_pkg::EIPL_LATCHED; // see RULE8
        else if (pinLevel || !cur_r.mode)
          cur_nxt.state = eipl_pkg::EIPL_IDLE; // see RULE4
      end
      // unused code: fall back to idle
      default:
        cur_nxt.state = eipl_pkg::EIPL_IDLE;
    endcase
    // level held low in mode 1 keeps the request alive
    if (cur_r.mode && !pinLevel && cur_nxt.state == eipl_pkg::EIPL_IDLE && cur_r.state == eipl_pkg::EIPL_IDLE)
      cur_nxt.state = eipl_pkg::EIPL_LATCHED; // see RULE3
    if (regWr)
    begin
      unique case (regAddr)
        `EIPL_STATUS_CTRL:
        begin
          cur_nxt.mask = regWrData[`EIPL_BIT_MASK];
          cur_nxt.mode = regWrData[`EIPL_BIT_MODE];
        end
        `EIPL_BREAK_CTRL:
          cur_nxt.breakClrEn = regWrData[`EIPL_BIT_BCE];
        default:
          ;
      endcase
    end
    if (regRd)
    begin
      unique case (regAddr)
        `EIPL_STATUS_CTRL:
          cur_nxt.rdData = {3'h0, pinLevel, latched, 1'b0, cur_r.mask, cur_r.mode}; // see RULE12 see RULE13
        `EIPL_BREAK_CTRL:
          cur_nxt.rdData = {7'h00, cur_r.breakClrEn};
        `EIPL_VECTOR_HI:
          cur_nxt.rdData = 8'(`EIPL_VEC_ADDR_HI >> 8);
        `EIPL_VECTOR_LO:
          cur_nxt.rdData = 8'(`EIPL_VEC_ADDR_LO);
        default:
          cur_nxt.rdData = 8'h00;
      endcase
    end
  end

  // reset clears latch and mode even with the pin low
  always_ff @(posedge sys_clk or negedge rst_b)
    if (!rst_b)
      cur_r <= '{state: eipl_pkg::EIPL_IDLE, mode: 1'b0, mask: 1'b0, breakClrEn: 1'b0, rdData: 8'h00}; // see RULE10
    else
      cur_r <= cur_nxt;
endmodule // eipl_irq_latch

// ==== src/eipl_defines.svh ====
// offsets, field positions, vector addresses and sync depth of the external interrupt pin latch
`ifndef EIPL_DEFINES_SVH
`define EIPL_DEFINES_SVH
`define EIPL_ADDR_W        4
`define EIPL_STATUS_CTRL   4'h0
`define EIPL_BREAK_CTRL    4'h1
`define EIPL_VECTOR_HI     4'h2
`define EIPL_VECTOR_LO     4'h3
`define EIPL_BIT_MASK      1
`define EIPL_BIT_ACK       2
`define EIPL_BIT_PEND      3
`define EIPL_BIT_MODE      0
`define EIPL_BIT_PIN       4
`define EIPL_BIT_BCE       0
`define EIPL_VEC_ADDR_HI   16'hfffa
`define EIPL_VEC_ADDR_LO   16'hfffb
`define EIPL_SYNC_STAGES   2
`endif

// ==== src/eipl_pkg.sv ====
// types of the external interrupt pin latch
package eipl_pkg;
  typedef enum logic [1:0] {EIPL_IDLE, EIPL_LATCHED, EIPL_HELD} eipl_state_t;
  typedef struct packed {
    eipl_state_t state;
    logic        mode;
    logic        mask;
    logic        breakClrEn;
    logic [7:0]  rdData;
  } eipl_regs_t;
endpackage

// ==== src/eipl_pin_sync.sv ====
// two-stage synchroniser for the interrupt pin, with falling edge detect
`timescale 1ns/1ps
`include "eipl_defines.svh"
module eipl_pin_sync #(
  parameter int STAGES = `EIPL_SYNC_STAGES
) (
  // clock and reset
  input  wire logic sysClk,
  input  wire logic rstB,
  // pin
  input  wire logic pinInB,
  // synchronised view
  output logic      pinLevel,
  output logic      fallPulse
);
  // fewer than two stages is not metastability safe
  if (STAGES < 2)
  begin : g_bad_stages
    $error("eipl_pin_sync: STAGES must be at least 2");
  end
  logic [STAGES:0] chain_r;
  logic [STAGES:0] arm_r;
  // reset to the idle level of the pulled-up pin
  always_ff @(posedge sysClk or negedge rstB)
    if (!rstB)
    begin
      chain_r <= '1;
      arm_r   <= '0;
    end
    else
    begin
      chain_r <= {chain_r[STAGES-1:0], pinInB};
      arm_r   <= {arm_r[STAGES-1:0], 1'b1};
    end
  assign pinLevel  = chain_r[STAGES-1]; // see RULE17
  // pin held low through reset is no edge; a real fall in the first cycles is lost
  assign fallPulse = arm_r[STAGES] & chain_r[STAGES] & ~chain_r[STAGES-1]; // see RULE1 see RULE10
endmodule // eipl_pin_sync

// ==== src/eipl_ack_gate.sv ====
// acknowledge pulse source: vector fetch or software, gated in break state
`timescale 1ns/1ps
module eipl_ack_gate (
  // causes
  input  wire logic vecFetch,
  input  wire logic swAck,
  input  wire logic breakState,
  input  wire logic breakClrEn,
  // result
  output logic      ackPulse
);
  // fetch always clears; software only if break-clear enabled during break
  assign ackPulse = vecFetch | (swAck & (~breakState | breakClrEn)); // see RULE6 see RULE7 see RULE14 see RULE15
endmodule // eipl_ack_gate

// ==== tb/eipl_irq_latch_properties.sv ====
// port assertions for the external interrupt pin latch
`timescale 1ns/1ps
`include "eipl_defines.svh"
module eipl_irq_latch_properties (
  // all one-bit ports
  input wire logic        sys_clk, rst_b, irqPinB, vecFetch, breakState, irqReq, pinHigh, regWr, regRd,
  // register port and vector
  input wire logic [`EIPL_ADDR_W-1:0] regAddr,
  input wire logic [7:0]  regWrData, regRdData,
  input wire logic [15:0] vectorAddr
);
  logic modeR, maskR, bceR;
  wire  wrSc = regWr && regAddr == `EIPL_STATUS_CTRL;
  wire  ackW = wrSc && regWrData[`EIPL_BIT_ACK];
  always_ff @(posedge sys_clk or negedge rst_b)
    if (!rst_b)
      {modeR, maskR, bceR} <= 3'h0;
    else
    begin
      if (wrSc)
        {maskR, modeR} <= regWrData[1:0];
      if (regWr && regAddr == `EIPL_BREAK_CTRL)
        bceR <= regWrData[`EIPL_BIT_BCE];
    end
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_b);
  property p_vec; vectorAddr == `EIPL_VEC_ADDR_HI; endproperty
  a_vec: assert property (p_vec) else $error("vector address wrong");
  property p_mask; maskR |-> !irqReq; endproperty
  a_mask: assert property (p_mask) else $error("masked request seen");
  property p_hi; irqPinB[*3] |-> pinHigh; endproperty
  a_hi: assert property (p_hi) else $error("pin level not high");
  property p_lvl; (modeR && !maskR && !pinHigh)[*3] |-> irqReq; endproperty
  a_lvl: assert property (p_lvl) else $error("low level not requesting");
  // reset held the sync high, so a fall right after it is no edge
  property p_edge; !modeR && !maskR && $fell(pinHigh) && $past(rst_b, 4) |-> ##[0:3] irqReq; endproperty
  a_edge: assert property (p_edge) else $error("edge not latched");
  property p_ack; ackW && !breakState && regWrData[1:0] == 2'h0 && pinHigh && $past(pinHigh) |=> !irqReq; endproperty
  a_ack: assert property (p_ack) else $error("software ack kept request");
  property p_vf; vecFetch && !modeR && !regWr && pinHigh && $past(pinHigh) |=> !irqReq; endproperty
  a_vf: assert property (p_vf) else $error("vector fetch kept request");
  // a held request may still end by the pin going high, so only a low pin or edge mode counts
  property p_brk; ackW && breakState && !bceR && !vecFetch && !regWrData[1] && irqReq && $stable(modeR) &&
    (!modeR || !pinHigh) |=> irqReq; endproperty
  a_brk: assert property (p_brk) else $error("ack in break changed flag");
  property p_rd; regRd && regAddr == `EIPL_STATUS_CTRL && !maskR |=>
    regRdData[`EIPL_BIT_PEND] == $past(irqReq) && regRdData[`EIPL_BIT_PIN] == $past(pinHigh); endproperty
  a_rd: assert property (p_rd) else $error("status read wrong");
  c_edge: cover property (irqReq && !modeR);
  c_lvl: cover property (modeR && irqReq && !pinHigh);
  c_brk: cover property (ackW && breakState);
endmodule // eipl_irq_latch_properties
bind eipl_irq_latch eipl_irq_latch_properties eipl_irq_latch_properties_i (.*);

// ==== tb/eipl_pin_source.sv ====
// pin source model driving the active-low interrupt pin
`timescale 1ns/1ps
module eipl_pin_source (
  input wire logic       sys_clk, lvl,
  input wire logic [2:0] dly,
  output logic           irqPinB
);
  // pulled up when idle; lags by dly cycles to act as a slow source
  initial
  begin
    irqPinB = 1'h1;
    forever
    begin
      @(posedge sys_clk);
      if (lvl !== irqPinB)
      begin
        repeat (dly) @(posedge sys_clk);
        irqPinB <= lvl;
      end
    end
  end
endmodule // eipl_pin_source

// ==== tb/eipl_irq_latch_tb_top.sv ====
// self-checking bench for the external interrupt pin latch
`timescale 1ns/1ps
module eipl_irq_latch_tb_top;
  logic sys_clk = 0, rst_b = 0, lvl = 1, vecFetch = 0, breakState = 0, regWr = 0, regRd = 0;
  logic [2:0] dly = 3'h0;
  logic [3:0] regAddr = 4'h0;
  logic [7:0] regWrData = 8'h00, regRdData;
  logic irqPinB, irqReq, pinHigh;
  logic [15:0] vectorAddr;
  int failures = 0, comparisons = 0, m;
  always #2 sys_clk = ~sys_clk;
  eipl_pin_source eipl_pin_source_i (.sys_clk(sys_clk), .lvl(lvl), .dly(dly), .irqPinB(irqPinB));
  eipl_irq_latch eipl_irq_latch_i (.sys_clk(sys_clk), .rst_b(rst_b), .irqPinB(irqPinB), .vecFetch(vecFetch),
    .breakState(breakState), .irqReq(irqReq), .vectorAddr(vectorAddr), .pinHigh(pinHigh), .regAddr(regAddr),
    .regWrData(regWrData), .regWr(regWr), .regRd(regRd), .regRdData(regRdData));
  function automatic logic [7:0] stat(input logic pin, pend, mask, mode);
    return {3'h0, pin, pend, 1'h0, mask, mode};
  endfunction
  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk);
  endtask
  task automatic chk(input logic [15:0] got, exp);
    comparisons++;
    if (got !== exp)
    begin
      failures++;
      $display("CHECK FAILED %0t got %h want %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    {regWr, regAddr, regWrData} <= {1'h1, a, d};
    @(posedge sys_clk);
    regWr <= 1'h0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [7:0] e);
    @(posedge sys_clk);
    {regRd, regAddr} <= {1'h1, a};
    @(posedge sys_clk);
    regRd <= 1'h0;
    #1 chk(regRdData, e);
  endtask
  // slow enough for the longest source lag plus the sync chain
  task automatic pin(input logic l);
    @(posedge sys_clk);
    lvl <= l;
    cyc(14);
  endtask
  task automatic ack(input logic v, input logic [7:0] d);
    if (v)
    begin
      @(posedge sys_clk);
      vecFetch <= 1'h1;
      @(posedge sys_clk);
      vecFetch <= 1'h0;
    end
    else
      wr(4'h0, d);
  endtask
  task automatic complete_run;
    if (failures == 0 && comparisons > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  initial
  begin
    m = $urandom(88915);
    cyc(16);
    rst_b <= 1'h1;
    rd(4'h0, stat(1'h1, 1'h0, 1'h0, 1'h0));
    rd(4'h1, 8'h00);
    wr(4'hf, 8'hff);
    rd(4'hf, 8'h00);
    rd(4'h2, 8'hff);
    rd(4'h3, 8'hfb);
    chk(vectorAddr, 16'hfffa);
    for (int i = 0; i < 8; i++)
    begin
      m = (i < 4) ? i : $urandom % 4;
      dly <= 3'($urandom % 8);
      wr(4'h0, {7'h0, m[0]});
      pin(1'h0);
      chk(irqReq, 16'h1);
      chk(pinHigh, 16'h0);
      rd(4'h0, stat(1'h0, 1'h1, 1'h0, m[0]));
      pin(1'h1);
      chk(irqReq, 16'h1);
      chk(pinHigh, 16'h1);
      ack(m[1], {7'h2, m[0]});
      cyc(2);
      chk(irqReq, 16'h0);
    end
    wr(4'h0, 8'h01);
    pin(1'h0);
    ack(1'h0, 8'h05);
    cyc(4);
    chk(irqReq, 16'h1);
    // handler masks further requests while the level is still low
    wr(4'h0, 8'h03);
    cyc(2);
    chk(irqReq, 16'h0);
    rd(4'h0, stat(1'h0, 1'h1, 1'h1, 1'h1));
    pin(1'h1);
    wr(4'h0, 8'h01);
    cyc(2);
    chk(irqReq, 16'h0);
    wr(4'h0, 8'h02);
    pin(1'h0);
    chk(irqReq, 16'h0);
    rd(4'h0, stat(1'h0, 1'h1, 1'h1, 1'h0));
    pin(1'h1);
    wr(4'h0, 8'h00);
    pin(1'h0);
    breakState <= 1'h1;
    wr(4'h0, 8'h04);
    cyc(2);
    chk(irqReq, 16'h1);
    wr(4'h1, 8'h01);
    wr(4'h0, 8'h04);
    breakState <= 1'h0;
    cyc(4);
    chk(irqReq, 16'h0);
    wr(4'h0, 8'h01);
    pin(1'h1);
    pin(1'h0);
    rst_b <= 1'h0;
    cyc(2);
    rst_b <= 1'h1;
    cyc(8);
    chk(irqReq, 16'h0);
    rd(4'h0, stat(1'h0, 1'h0, 1'h0, 1'h0));
    complete_run;
  end
  initial
  begin
    cyc(8000);
    failures++;
    complete_run;
  end
endmodule // eipl_irq_latch_tb_top
